// ---- src/port_c_function_select_block.sv ----
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: one 16-bit read/write register; bit n picks the function of pin n.
// R2: power-on reset clears the register, so every pin is general I/O.
// R3: watchdog reset, standby and sleep leave the register unchanged.
// R4: bits 15 to 12: 0 general I/O, 1 address bits 15 to 12.
// R5: bits 11 to 8: 0 general I/O, 1 address bits 11 to 8.
// R6: bits 7 to 4: 0 general I/O, 1 address bits 7 to 4.
// R7: bits 3 to 0: 0 general I/O, 1 address bits 3 to 0.
// R8: in general I/O, direction bit 1 drives the pin, 0 leaves it input.
// R9: address pins drive the same-index address bit, direction bit ignored.
module port_c_function_select_block
    import port_c_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        watchdog_reset,
    input  wire logic        standby,
    input  wire logic        sleep,
    input  wire logic [15:0] direction_select,
    input  wire logic [15:0] address_bus,
    input  wire logic [15:0] gpio_out_data,
    input  wire logic [15:0] pin_in,
    output var  logic [15:0] pin_out,
    output var  logic [15:0] pin_oe,
    output var  logic [15:0] gpio_in_data,
    output var  logic [15:0] port_c_function_select
);

    import port_c_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == FUNCTION_SELECT_OFFSET) ||
                    (addr == PIN_LEVEL_OFFSET) ||
                    (addr == PIN_ENABLE_OFFSET);
    endfunction : is_mapped

    function automatic logic [15:0] merge_bytes(input logic [15:0] old_value,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  strb);
        merge_bytes[7:0]  = strb[0] ? wdata[7:0]  : old_value[7:0];
        merge_bytes[15:8] = strb[1] ? wdata[15:8] : old_value[15:8];
    endfunction : merge_bytes

    // ------------------------------------------------------------
    // apb answer state
    // ------------------------------------------------------------
    apb_phase_type phase;
    apb_phase_type next_phase;
    logic          next_pready;
    logic          next_pslverr;
    logic [31:0]   next_prdata;
    logic          write_commit;
    logic [15:0]   next_function_select;
    logic [15:0]   next_gpio_in_data;

    assign write_commit = psel && penable && pready && pwrite && !pslverr &&
                          (paddr == FUNCTION_SELECT_OFFSET);

    always_comb begin
        next_phase   = phase;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        unique case (phase)
            phase_idle: begin
                if (psel && penable) begin
                    next_phase   = phase_answer;
                    next_pready  = 1'b1;
                    next_pslverr = !is_mapped(paddr);
                    next_prdata  = READ_DATA_RESET;
                    if (!pwrite) begin
                        unique case (paddr)
                            FUNCTION_SELECT_OFFSET: next_prdata = {16'h0000, port_c_function_select}; // [R1]
                            PIN_LEVEL_OFFSET:       next_prdata = {16'h0000, gpio_in_data};
                            PIN_ENABLE_OFFSET:      next_prdata = {16'h0000, pin_oe};
                            default:                next_prdata = READ_DATA_RESET;
                        endcase
                    end
                end
            end
            phase_answer: begin
                next_phase = phase_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase   <= phase_idle;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= READ_DATA_RESET;
        end else begin
            phase   <= next_phase;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // function select register and pin level sampling
    // ------------------------------------------------------------
    always_comb begin
        next_function_select = port_c_function_select;
        if (write_commit) begin
            next_function_select = merge_bytes(port_c_function_select, pwdata, pstrb); // [R1]
        end
        next_gpio_in_data = pin_in;
    end

    // only power-on reset clears; the low power and watchdog inputs do not reach this register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_c_function_select <= FUNCTION_SELECT_RESET; // [R2]
            gpio_in_data           <= PIN_RESET;
        end else begin
            port_c_function_select <= next_function_select; // [R3]
            gpio_in_data           <= next_gpio_in_data;
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    pin_route route (
        .clk              (clk),
        .rst_b            (rst_b),
        .function_select  (port_c_function_select),
        .direction_select (direction_select),
        .address_bus      (address_bus),
        .gpio_out_data    (gpio_out_data),
        .pin_out          (pin_out),
        .pin_oe           (pin_oe)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence apb_setup;
        psel && !penable;
    endsequence

    sequence apb_wait;
        psel && penable && !pready;
    endsequence

    sequence apb_done;
        psel && penable && pready;
    endsequence

    property answer_after_wait;
        @(posedge clk) disable iff (!rst_b)
        apb_setup ##1 apb_wait |=> pready;
    endproperty

    property single_answer;
        @(posedge clk) disable iff (!rst_b)
        apb_done |=> !pready;
    endproperty

    property write_lands;
        @(posedge clk) disable iff (!rst_b)
        write_commit |=>
            port_c_function_select == merge_bytes($past(port_c_function_select), $past(pwdata), $past(pstrb));
    endproperty

    property read_returns;
        @(posedge clk) disable iff (!rst_b)
        (apb_wait and (!pwrite && paddr == FUNCTION_SELECT_OFFSET))
            |=> prdata == {16'h0000, port_c_function_select};
    endproperty

    property group_routes(int lsb);
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> ((pin_out[lsb +: GROUP_WIDTH] & $past(port_c_function_select[lsb +: GROUP_WIDTH])) ==
                 ($past(address_bus[lsb +: GROUP_WIDTH]) & $past(port_c_function_select[lsb +: GROUP_WIDTH])));
    endproperty

    a_apb_answer: assert property (answer_after_wait) // [R1]
        else $error("bus answer missing one cycle after wait");

    a_apb_single: assert property (single_answer) // [R1]
        else $error("ready held for more than one cycle");

    a_write_lands: assert property (write_lands) // [R1]
        else $error("written value not stored");

    a_read_returns: assert property (read_returns) // [R1]
        else $error("read data differs from register");

    a_reset_clear: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> (port_c_function_select == FUNCTION_SELECT_RESET && pin_oe == PIN_RESET))
        else $error("register not clear after power-on reset");

    a_hold_low_power: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_b)
        ((watchdog_reset || standby || sleep) && !write_commit) |=> $stable(port_c_function_select))
        else $error("register changed on watchdog reset or low power");

    a_hold_no_write: assert property ( // [R3]
        @(posedge clk) disable iff (!rst_b)
        !write_commit [*2] |=> $stable(port_c_function_select))
        else $error("register changed without a write");

    a_high_group: assert property (group_routes(GROUP_HIGH_LSB)) // [R4]
        else $error("pins 15 to 12 not driven from address");

    a_upper_group: assert property (group_routes(GROUP_UPPER_LSB)) // [R5]
        else $error("pins 11 to 8 not driven from address");

    a_lower_group: assert property (group_routes(GROUP_LOWER_LSB)) // [R6]
        else $error("pins 7 to 4 not driven from address");

    a_low_group: assert property (group_routes(GROUP_LOW_LSB)) // [R7]
        else $error("pins 3 to 0 not driven from address");

    a_gpio_direction: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_b)
        rst_b |=> ((pin_oe & ~$past(port_c_function_select)) ==
                  ($past(direction_select) & ~$past(port_c_function_select))) &&
                 ((pin_out & ~$past(port_c_function_select)) ==
                  ($past(gpio_out_data) & ~$past(port_c_function_select))))
        else $error("general I/O pin not following direction");

    a_address_drive: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_b)
        1'b1 |=> (pin_oe & $past(port_c_function_select)) == $past(port_c_function_select))
        else $error("address pin not driven");

    a_write_to_pin: assert property ( // [R9]
        @(posedge clk) disable iff (!rst_b)
        (write_commit && pstrb[0] && pwdata[0]) |=> ##1 pin_oe[0])
        else $error("pin 0 not driven after selecting address");

    // ------------------------------------------------------------
    // bus map checks
    // ------------------------------------------------------------
    sequence apb_read_wait;
        apb_wait and !pwrite;
    endsequence

    a_error_unmapped: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_b)
        (apb_wait and !is_mapped(paddr)) |=> (pready && pslverr && prdata == READ_DATA_RESET))
        else $error("unmapped access not refused");

    a_mapped_ok: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_b)
        (apb_wait and is_mapped(paddr)) |=> (pready && !pslverr))
        else $error("error raised for a mapped register");

    a_error_with_ready: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_b)
        pslverr |-> pready)
        else $error("error shown without ready");

    a_level_read: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_b)
        (apb_read_wait and paddr == PIN_LEVEL_OFFSET) |=> prdata == {16'h0000, $past(gpio_in_data)})
        else $error("pin level read differs from sampled pins");

    a_enable_read: assert property ( // [R8] [R9]
        @(posedge clk) disable iff (!rst_b)
        (apb_read_wait and paddr == PIN_ENABLE_OFFSET) |=> prdata == {16'h0000, $past(pin_oe)})
        else $error("output enable read differs from pins");

    a_ignored_write: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_b)
        (apb_done and (pwrite && paddr != FUNCTION_SELECT_OFFSET)) |=> $stable(port_c_function_select))
        else $error("register changed by a write to another offset");

    a_level_sample: assert property ( // [R8]
        @(posedge clk) disable iff (!rst_b)
        rst_b |=> gpio_in_data == $past(pin_in))
        else $error("pin level not sampled");

    a_ready_idle: assert property ( // [R1]
        @(posedge clk) disable iff (!rst_b)
        !psel |=> !pready)
        else $error("ready without a selected transfer");

    a_bus_reset: assert property ( // [R2]
        @(posedge clk) disable iff (!rst_b)
        !$past(rst_b) |-> (!pready && !pslverr && prdata == READ_DATA_RESET && pin_out == PIN_RESET))
        else $error("bus outputs not clear after power-on reset");

endmodule : port_c_function_select_block

`default_nettype wire

// ---- src/port_c_pkg.sv ----
package port_c_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 12;
    localparam int STRB_WIDTH = 4;
    localparam int PIN_COUNT  = 16;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] FUNCTION_SELECT_OFFSET = 12'h000;
    localparam logic [11:0] PIN_LEVEL_OFFSET       = 12'h004;
    localparam logic [11:0] PIN_ENABLE_OFFSET      = 12'h008;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] FUNCTION_SELECT_RESET = 16'h0000;
    localparam logic [15:0] PIN_RESET             = 16'h0000;
    localparam logic [31:0] READ_DATA_RESET       = 32'h0000_0000;

    // ------------------------------------------------------------
    // field positions: four groups of address pins
    // ------------------------------------------------------------
    localparam int GROUP_HIGH_LSB  = 12;
    localparam int GROUP_UPPER_LSB = 8;
    localparam int GROUP_LOWER_LSB = 4;
    localparam int GROUP_LOW_LSB   = 0;
    localparam int GROUP_WIDTH     = 4;

    // ------------------------------------------------------------
    // bus answer phases
    // ------------------------------------------------------------
    typedef enum logic {
        phase_idle,
        phase_answer
    } apb_phase_type;

endpackage : port_c_pkg

// ---- src/pin_route.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_route
    import port_c_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] function_select,
    input  wire logic [15:0] direction_select,
    input  wire logic [15:0] address_bus,
    input  wire logic [15:0] gpio_out_data,
    output var  logic [15:0] pin_out,
    output var  logic [15:0] pin_oe
);

    // ------------------------------------------------------------
    // per pin routing
    // ------------------------------------------------------------
    logic [15:0] next_pin_out;
    logic [15:0] next_pin_oe;

    always_comb begin
        next_pin_out = (function_select & address_bus) |   // [R4] [R5] [R6] [R7] [R9]
                       (~function_select & gpio_out_data); // [R8]
        next_pin_oe  = function_select | (~function_select & direction_select);              // [R9] [R8]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= PIN_RESET;
            pin_oe  <= PIN_RESET;
        end else begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

endmodule : pin_route

`default_nettype wire

// ---- test/port_c_function_select_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module port_c_function_select_test;
    import port_c_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wdog = 1'b0;
    logic        standby = 1'b0;
    logic        sleep = 1'b0;
    logic [15:0] dir = 16'hA5C3;
    logic [15:0] abus = 16'h1234;
    logic [15:0] gpio = 16'h3C5A;
    logic [15:0] pin_in = 16'h6A59;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] gpio_in;
    logic [15:0] func_sel;
    logic [31:0] rdata;
    logic        rerr;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [15:0] sel_tab [5] = '{16'h000F, 16'h00F0, 16'h0F00, 16'hF000, 16'h5AA5};

    always #5 clk = ~clk;

    port_c_function_select_block dut (
        .clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_reset(wdog), .standby(standby), .sleep(sleep),
        .direction_select(dir), .address_bus(abus), .gpio_out_data(gpio), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .gpio_in_data(gpio_in), .port_c_function_select(func_sel)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        pstrb   <= strb;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic pins(input logic [15:0] m);
        logic [15:0] oe;
        oe = m | (dir & ~m);
        repeat (2) @(posedge clk);
        check({16'h0000, func_sel}, {16'h0000, m});
        check({16'h0000, gpio_in}, {16'h0000, pin_in});
        check({16'h0000, pin_oe}, {16'h0000, oe});
        check({16'h0000, pin_out & oe}, {16'h0000, ((abus & m) | (gpio & ~m)) & oe});
    endtask : pins

    // ------------------------------------------------------------
    // timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, FUNCTION_SELECT_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, 32'h0000_0000);
        pins(16'h0000);
        for (int i = 0; i < 5; i++) begin
            abus <= 16'h1234 ^ {sel_tab[i][7:0], sel_tab[i][15:8]};
            apb(1'b1, FUNCTION_SELECT_OFFSET, {16'hFFFF, sel_tab[i]}, 4'hF);
            pins(sel_tab[i]);
            apb(1'b0, FUNCTION_SELECT_OFFSET, 32'h0000_0000, 4'h0);
            check(rdata, {16'h0000, sel_tab[i]});
        end
        apb(1'b1, FUNCTION_SELECT_OFFSET, 32'h0000_00FF, 4'h1);
        apb(1'b1, FUNCTION_SELECT_OFFSET, 32'h0000_12EE, 4'h2);
        apb(1'b0, FUNCTION_SELECT_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, 32'h0000_12FF);
        apb(1'b1, FUNCTION_SELECT_OFFSET, 32'h0000_C3A5, 4'h3);
        wdog <= 1'b1;
        dir <= 16'h5A3C;
        pin_in <= 16'h95A6;
        repeat (4) @(posedge clk);
        wdog    <= 1'b0;
        standby <= 1'b1;
        repeat (4) @(posedge clk);
        standby <= 1'b0;
        sleep   <= 1'b1;
        repeat (4) @(posedge clk);
        sleep <= 1'b0;
        pins(16'hC3A5);
        apb(1'b0, FUNCTION_SELECT_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, 32'h0000_C3A5);
        apb(1'b1, 12'h00C, 32'h0000_FFFF, 4'hF);
        check({31'h0, rerr}, 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0000_0000, 4'h0);
        check({31'h0, rerr}, 32'h0000_0001);
        check(rdata, 32'h0000_0000);
        apb(1'b1, PIN_ENABLE_OFFSET, 32'h0000_FFFF, 4'hF);
        check({31'h0, rerr}, 32'h0000_0000);
        apb(1'b0, PIN_LEVEL_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, {16'h0000, pin_in});
        apb(1'b0, PIN_ENABLE_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, {16'h0000, 16'hC3A5 | (dir & ~16'hC3A5)});
        pins(16'hC3A5);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        check({16'h0000, func_sel}, 32'h0000_0000);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, FUNCTION_SELECT_OFFSET, 32'h0000_0000, 4'h0);
        check(rdata, 32'h0000_0000);
        pins(16'h0000);
        print_verdict();
    end

endmodule : port_c_function_select_test

`default_nettype wire
